/* hw/irq_controller.sv */
// interrupt controller: source latching, fast/normal split, two-level
// rotating arbitration, service pending and pending index
// assumes a register port with read data one cycle after the read strobe,
// and request inputs synchronous to CLK_SYS_I
`include "irq_regs.svh"
`default_nettype none
module irq_controller (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire irq_pkg::word_type ADDR_I,
	input wire irq_pkg::word_type WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output irq_pkg::word_type RDATA_O,
	input wire irq_pkg::word_type SRC_REQ_I,
	input wire logic [23:0] EXT_LINE_I,
	input wire logic [2:0] SERIAL0_SUB_I,
	input wire logic [2:0] SERIAL1_SUB_I,
	input wire logic [2:0] SERIAL2_SUB_I,
	input wire logic [1:0] WDT_AUDIO_SUB_I,
	output logic FIQ_O,
	output logic IRQ_O
);
	import irq_pkg::*;

	// ****************************************************************
	// state and decode
	// ****************************************************************

	word_type source_request_latch_q;
	word_type source_request_latch_d;
	word_type fast_group_select_q;
	word_type source_mask_q;
	word_type service_pending_q;
	word_type service_pending_d;
	logic [`IRQ_PRIO_W-1:0] prio_q;
	bit_type pending_index_q;
	logic fiq_q;
	word_type rdata_q;
	word_type primary_req;
	word_type normal_cand;
	logic [35:0] padded;
	logic wr_src;
	logic wr_mode;
	logic wr_mask;
	logic wr_prio;
	logic wr_svc;
	logic load;
	bit_type win_bit;
	logic [5:0] flat_idx;
	idx_type top_grp;
	logic [`IRQ_ARBS-1:0] grp_valid;
	idx_type grp_idx [`IRQ_ARBS];
	sel_type grp_next [`IRQ_ARBS];
	logic [`IRQ_ARBS-1:0] rot_en;
	sel_type grp_sel [`IRQ_ARBS];

	// write strobes per register; full address compare, no aliasing
	assign wr_src = WR_I && (ADDR_I == `IRQ_ADDR_SRC);
	assign wr_mode = WR_I && (ADDR_I == `IRQ_ADDR_MODE);
	assign wr_mask = WR_I && (ADDR_I == `IRQ_ADDR_MASK);
	assign wr_prio = WR_I && (ADDR_I == `IRQ_ADDR_PRIO);
	assign wr_svc = WR_I && (ADDR_I == `IRQ_ADDR_SVC);

	// ****************************************************************
	// request combining
	// ****************************************************************

	// shared lines are ORs of their sub-requests; the direct input bits at
	// these positions are ignored so a sub-source cannot be bypassed
	always_comb begin
		primary_req = SRC_REQ_I;
		primary_req[3:0] = EXT_LINE_I[3:0];
		primary_req[`IRQ_BIT_EXT4_7] = |EXT_LINE_I[7:4]; // [R02]
		primary_req[`IRQ_BIT_EXT8_23] = |EXT_LINE_I[23:8]; // [R02]
		primary_req[`IRQ_BIT_WDT_AUDIO] = |WDT_AUDIO_SUB_I; // [R02]
		primary_req[`IRQ_BIT_SERIAL2] = |SERIAL2_SUB_I; // [R02]
		primary_req[`IRQ_BIT_SERIAL1] = |SERIAL1_SUB_I; // [R02]
		primary_req[`IRQ_BIT_SERIAL0] = |SERIAL0_SUB_I; // [R02]
	end

	// ****************************************************************
	// source pending
	// ****************************************************************

	// set wins over clear: a request arriving during its own clear survives;
	// the mask plays no part here and the arbiter never writes this
	always_comb begin
		source_request_latch_d = source_request_latch_q; // [R12]
		if (wr_src) begin
			source_request_latch_d = source_request_latch_q & ~WDATA_I; // [R13]
		end
		source_request_latch_d = source_request_latch_d | primary_req; // [R11]
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			source_request_latch_q <= `IRQ_SRC_RST;
		end else begin
			source_request_latch_q <= source_request_latch_d;
		end
	end

	// ****************************************************************
	// mode and mask
	// ****************************************************************

	// mode bit 1 routes a source to the fast group; one-hot use is up to software
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			fast_group_select_q <= `IRQ_MODE_RST;
		end else if (wr_mode) begin
			fast_group_select_q <= WDATA_I;
		end
	end

	// everything starts masked
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			source_mask_q <= `IRQ_MASK_RST; // [R22]
		end else if (wr_mask) begin
			source_mask_q <= WDATA_I;
		end
	end

	// ****************************************************************
	// arbitration tree
	// ****************************************************************

	// a pending bit that software left set keeps competing, so the same
	// source re-enters service after its handler returns
	assign normal_cand = source_request_latch_d & ~source_mask_q & ~fast_group_select_q; // [R14] [R16] [R17] [R20]

	// groups 0 and 5 have four sources, padded at the top with idle inputs;
	// inside a group inputs rise with the source bit number
	assign padded = {2'b00, normal_cand[31:28], normal_cand[27:4], 2'b00, normal_cand[3:0]}; // [R09] [R10] [R23] [R24]

	// six first-level arbiters and one second level over their winners
	for (genvar g = 0; g < `IRQ_ARBS; g++) begin : gen_arb
		arb_if a_if ();
		if (g < `IRQ_GROUPS) begin : gen_first
			assign a_if.req = padded[6*g +: 6]; // [R03]
		end else begin : gen_second
			assign a_if.req = grp_valid[`IRQ_GROUPS-1:0]; // [R03] [R23]
		end
		assign rot_en[g] = prio_q[g*`IRQ_ARB_FIELD_W]; // [R04]
		assign grp_sel[g] = prio_q[g*`IRQ_ARB_FIELD_W+`IRQ_PRIORITY_SELECT_OFS +: 2]; // [R04]
		assign a_if.sel = grp_sel[g];
		assign grp_valid[g] = a_if.valid;
		assign grp_idx[g] = a_if.idx;
		assign grp_next[g] = a_if.next_sel;
		rotating_arbiter u_arb (
			.bus(a_if.arbiter)
		);
	end

	// map winner back to a source bit: group 0 starts at bit 0, later
	// groups sit two below their padded position
	assign top_grp = grp_idx[`IRQ_ARBS-1];
	assign flat_idx = 6'(6 * int'(top_grp)) + 6'(grp_idx[top_grp]);
	assign win_bit = (top_grp == 3'h0) ? flat_idx[4:0] : 5'(flat_idx - 6'h02);

	// a new winner is taken only while no service bit is outstanding
	always_comb begin
		service_pending_d = service_pending_q;
		if (wr_svc) begin
			service_pending_d = service_pending_q & ~WDATA_I;
		end
		load = (service_pending_d == '0) && grp_valid[`IRQ_ARBS-1];
		if (load) begin
			service_pending_d = word_type'(1) << win_bit; // [R15]
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			service_pending_q <= `IRQ_SVC_RST;
		end else begin
			service_pending_q <= service_pending_d;
		end
	end

	// index follows the loaded winner; fast sources never reach it
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			pending_index_q <= `IRQ_INDEX_RST;
		end else if (load) begin
			pending_index_q <= win_bit; // [R20]
		end
	end

	// ****************************************************************
	// priority rotation
	// ****************************************************************

	// only the arbiters on the served path rotate; a software write in the
	// same cycle wins, so software can always force a fixed order
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			prio_q <= `IRQ_PRIO_RST;
		end else if (wr_prio) begin
			prio_q <= WDATA_I[`IRQ_PRIO_W-1:0]; // [R07]
		end else if (load) begin
			for (int g = 0; g < `IRQ_ARBS; g++) begin
				if (rot_en[g] && ((g == `IRQ_ARBS - 1) || (g == int'(top_grp)))) begin
					prio_q[g*`IRQ_ARB_FIELD_W+`IRQ_PRIORITY_SELECT_OFS +: 2] <= grp_next[g]; // [R08]
				end
			end
		end
	end

	// ****************************************************************
	// core requests
	// ****************************************************************

	// fast request bypasses arbitration; registered to keep it glitch free
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			fiq_q <= 1'b0;
		end else begin
			fiq_q <= |(source_request_latch_d & fast_group_select_q & ~source_mask_q); // [R17]
		end
	end

	assign FIQ_O = fiq_q; // [R01]
	assign IRQ_O = |service_pending_q; // [R01]

	// ****************************************************************
	// register read
	// ****************************************************************

	// read data stand for exactly one cycle; unmapped addresses read zero
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= '0;
		end else if (RD_I) begin
			case (ADDR_I)
				`IRQ_ADDR_SRC: rdata_q <= source_request_latch_q;
				`IRQ_ADDR_MODE: rdata_q <= fast_group_select_q;
				`IRQ_ADDR_MASK: rdata_q <= source_mask_q;
				`IRQ_ADDR_PRIO: rdata_q <= word_type'(prio_q);
				`IRQ_ADDR_SVC: rdata_q <= service_pending_q;
				`IRQ_ADDR_INDEX: rdata_q <= word_type'(pending_index_q);
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign RDATA_O = rdata_q;

	// ****************************************************************
	// checks
	// ****************************************************************

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);

	property p_src_set;
		(primary_req != '0) |=> ((source_request_latch_q & $past(primary_req)) == $past(primary_req));
	endproperty
	a_src_set: assert property (p_src_set) else $error("request not latched"); // [R11]

	property p_src_w1c;
		(wr_src && primary_req == '0)
			|=> (source_request_latch_q == ($past(source_request_latch_q) & ~$past(WDATA_I)));
	endproperty
	a_src_w1c: assert property (p_src_w1c) else $error("source pending clear wrong"); // [R13]

	property p_src_hold;
		(!wr_src && primary_req == '0) |=> $stable(source_request_latch_q);
	endproperty
	a_src_hold: assert property (p_src_hold) else $error("source pending moved"); // [R12]

	property p_svc_onehot;
		$onehot0(service_pending_q);
	endproperty
	a_svc_onehot: assert property (p_svc_onehot) else $error("service pending not one-hot"); // [R15]

	property p_svc_legal;
		(service_pending_q == '0)
			|=> ((service_pending_q & ($past(source_mask_q) | $past(fast_group_select_q))) == '0);
	endproperty
	a_svc_legal: assert property (p_svc_legal) else $error("masked or fast source serviced"); // [R16]

	property p_irq_raise;
		(normal_cand != '0 && service_pending_q == '0 && !wr_svc) |=> IRQ_O;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("normal interrupt missing"); // [R01]

	property p_fiq_raise;
		((source_request_latch_d & fast_group_select_q & ~source_mask_q) != '0) |=> FIQ_O;
	endproperty
	a_fiq_raise: assert property (p_fiq_raise) else $error("fast interrupt missing"); // [R17]

	property p_fixed_sel;
		(!rot_en[`IRQ_ARBS-1] && !wr_prio) |=> $stable(grp_sel[`IRQ_ARBS-1]);
	endproperty
	a_fixed_sel: assert property (p_fixed_sel) else $error("fixed select changed"); // [R07]

	property p_rotate;
		(load && rot_en[`IRQ_ARBS-1] && !wr_prio && top_grp == 3'h4)
			|=> (grp_sel[`IRQ_ARBS-1] == 2'h0);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotation after input 4 wrong"); // [R08]

	property p_input0_wins;
		(normal_cand[0] && load) |=> (pending_index_q == 5'h00);
	endproperty
	a_input0_wins: assert property (p_input0_wins) else $error("input 0 did not win"); // [R06]
endmodule
`default_nettype wire

/* hw/rotating_arbiter.sv */
// six-input rotating priority arbiter, combinational
// assumes the owner holds the select field and applies next_sel on a grant
`include "irq_regs.svh"
`default_nettype none
module rotating_arbiter (
	arb_if.arbiter bus
);
	import irq_pkg::*;

	// input found at priority position p for a given select
	function automatic idx_type order_at(input int p, input sel_type sel);
		int r;
		r = 0;
		if (p == 0) begin
			return idx_type'(0);
		end
		if (p == 5) begin
			return idx_type'(5);
		end
		r = ((p - 1 + int'(sel)) % 4) + 1; // [R05]
		return idx_type'(r);
	endfunction

	// scan lowest priority first so the highest requester is kept last
	always_comb begin
		idx_type cand;
		cand = '0;
		bus.idx = '0;
		bus.valid = 1'b0;
		for (int p = 5; p >= 0; p--) begin
			cand = order_at(p, bus.sel); // [R06]
			if (bus.req[cand]) begin
				bus.idx = cand;
				bus.valid = 1'b1;
			end
		end
	end

	// select that pushes the granted input to the bottom of the rotation
	always_comb begin
		case (bus.idx)
			3'h1: bus.next_sel = `IRQ_SEL_AFTER_1; // [R08]
			3'h2: bus.next_sel = `IRQ_SEL_AFTER_2;
			3'h3: bus.next_sel = `IRQ_SEL_AFTER_3;
			3'h4: bus.next_sel = `IRQ_SEL_AFTER_4;
			default: bus.next_sel = bus.sel; // inputs 0 and 5 never rotate
		endcase
	end
endmodule
`default_nettype wire

/* include/arb_if.sv */
// carrier between the controller and one six-input rotating arbiter
// assumes the arbiter is purely combinational
`default_nettype none
interface arb_if;
	import irq_pkg::*;
	req6_type req;
	sel_type sel;
	logic valid;
	idx_type idx;
	sel_type next_sel;
	modport owner(output req, output sel, input valid, input idx, input next_sel);
	modport arbiter(input req, input sel, output valid, output idx, output next_sel);
endinterface
`default_nettype wire

/* include/irq_pkg.sv */
// shared types of the interrupt controller
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package irq_pkg;
	typedef logic [31:0] word_type;
	typedef logic [1:0] sel_type;
	typedef logic [2:0] idx_type;
	typedef logic [5:0] req6_type;
	typedef logic [4:0] bit_type;
endpackage
`default_nettype wire

/* include/irq_regs.svh */
// register map, reset values and field layout of the interrupt controller
// assumes a 32-bit register port with full byte addresses
// How it works
// [R01] after arbitration the controller raises fast or normal interrupt toward the core
// [R02] serial port, watchdog/audio and external sub-requests are ORed per primary line
// [R03] 32 primary requests resolved by six first-level and one second-level arbiter
// [R04] each arbiter has six inputs, one rotate-enable bit, two priority-select bits
// [R05] select 00,01,10,11 orders inputs 012345, 023415, 034125, 041235
// [R06] input 0 always wins, input 5 always loses, only inputs 1-4 rotate
// [R07] rotate-enable 0 keeps select fixed; software writes still take effect
// [R08] rotate-enable 1: granting 1,2,3,4 loads select 01,10,11,00; 0 and 5 leave it
// [R09] group 3 SD/DMA/display, group 4 I2C/USB/NAND/serial1/SPI0, group 5 the rest
// [R10] group 0 external 0-3, group 1 watchdog..external 8-23, group 2 serial2 and timers; the code also puts external 4-7 (bit 4) in group 1
// [R11] source pending bit sets on request whatever the mask bit
// [R12] arbitration never touches source pending; requests set, software clears
// [R13] write to source pending clears bits written 1, keeps bits written 0
// [R14] a source pending bit left at 1 stays a live request and re-triggers
// [R15] exactly one service pending bit, the winner's, set after arbitration
// [R16] masked request sets source pending only, never service pending
// [R17] latched requests split into fast and normal; only normal ones arbitrate
// [R18] software clears source pending first, then the service pending bit
// [R19] software clears source pending before re-enabling the source
// [R20] fast-group sources never set service pending nor pending index
// [R21] software selects fast mode for at most one source; 1 means fast
// [R22] after reset all 32 mask bits are 1
// [R23] second level takes group winners 0-5; groups ordered by ascending bit
// [R24] bit 0 is external 0 up to bit 31 the ADC/touch source
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

`define IRQ_ADDR_SRC 32'h4A00_0000
`define IRQ_ADDR_MODE 32'h4A00_0004
`define IRQ_ADDR_MASK 32'h4A00_0008
`define IRQ_ADDR_PRIO 32'h4A00_000C
`define IRQ_ADDR_SVC 32'h4A00_0010
`define IRQ_ADDR_INDEX 32'h4A00_0014

`define IRQ_SRC_RST 32'h0000_0000
`define IRQ_MODE_RST 32'h0000_0000
`define IRQ_MASK_RST 32'hFFFF_FFFF
`define IRQ_PRIO_RST 21'h00_0000
`define IRQ_SVC_RST 32'h0000_0000
`define IRQ_INDEX_RST 5'h00

// priority register: per arbiter a 3-bit field, rotate-enable then select
`define IRQ_ARBS 7
`define IRQ_GROUPS 6
`define IRQ_ARB_FIELD_W 3
`define IRQ_PRIORITY_SELECT_OFS 1
`define IRQ_PRIO_W 21

// primary bit positions of the combined lines
`define IRQ_BIT_EXT4_7 4
`define IRQ_BIT_EXT8_23 5
`define IRQ_BIT_WDT_AUDIO 9
`define IRQ_BIT_SERIAL2 15
`define IRQ_BIT_SERIAL1 23
`define IRQ_BIT_SERIAL0 28

// select value loaded after granting inputs 1..4
`define IRQ_SEL_AFTER_1 2'h1
`define IRQ_SEL_AFTER_2 2'h2
`define IRQ_SEL_AFTER_3 2'h3
`define IRQ_SEL_AFTER_4 2'h0

`endif

/* tb/core_model.sv */
// model of the processor core that takes fast and normal interrupts
// assumes both request lines are levels synchronous to the system clock
`default_nettype none
module core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fiq_i,
	input wire logic irq_i,
	output var int fiq_taken_o,
	output var int irq_taken_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic fiq_q;
	logic irq_q;

	// the core enters a handler on each rising request; it never refuses one
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fiq_q <= 1'b0;
			irq_q <= 1'b0;
			fiq_taken_o <= 0;
			irq_taken_o <= 0;
		end else begin
			fiq_q <= fiq_i;
			irq_q <= irq_i;
			if (fiq_i && !fiq_q) fiq_taken_o <= fiq_taken_o + 1;
			if (irq_i && !irq_q) irq_taken_o <= irq_taken_o + 1;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the interrupt controller: register port, request
// mapping, two-level rotating arbitration, fast path
// assumes the controller and the core model are compiled alongside
`include "irq_regs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_pkg::*;
	logic clk, rst, wr_s, rd_s, fiq, irq;
	word_type addr, wdata, rdata, src_req, pend;
	logic [23:0] ext;
	logic [2:0] s0, s1, s2;
	logic [1:0] wa;
	logic [20:0] prio_m;
	int num_errors, checks, fiq_n, irq_n, w, n;

	irq_controller dut (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SRC_REQ_I(src_req), .EXT_LINE_I(ext),
		.SERIAL0_SUB_I(s0), .SERIAL1_SUB_I(s1), .SERIAL2_SUB_I(s2),
		.WDT_AUDIO_SUB_I(wa), .FIQ_O(fiq), .IRQ_O(irq));
	core_model core (.clk_i(clk), .rst_i(rst), .fiq_i(fiq), .irq_i(irq),
		.fiq_taken_o(fiq_n), .irq_taken_o(irq_n));

	// ****************************************
	// reference model of the arbiters
	// ****************************************
	function automatic int arb6(req6_type r, sel_type s);
		int k;
		if (r[0]) return 0;
		for (k = 0; k < 4; k++) begin
			if (r[((s + k) % 4) + 1]) return ((s + k) % 4) + 1;
		end
		if (r[5]) return 5;
		return -1;
	endfunction
	function automatic int gbase(int g);
		return (g == 0) ? 0 : 6 * g - 2;
	endfunction
	function automatic req6_type grp(word_type p, int g);
		req6_type r;
		int i;
		r = '0;
		for (i = 0; i < ((g == 0 || g == 5) ? 4 : 6); i++) r[i] = p[gbase(g) + i];
		return r;
	endfunction
	// rotation only moves the select field when its enable bit is set
	function automatic void rotate(int a, int inp);
		if (prio_m[3 * a] && inp >= 1 && inp <= 4) prio_m[3 * a + 2 -: 2] = 2'(inp % 4);
	endfunction
	function automatic int pick(word_type p);
		req6_type top;
		int g, w1, w2;
		for (g = 0; g < 6; g++) top[g] = |grp(p, g);
		w2 = arb6(top, prio_m[20:19]);
		w1 = arb6(grp(p, w2), prio_m[3 * w2 + 2 -: 2]);
		rotate(6, w2);
		rotate(w2, w1);
		return gbase(w2) + w1;
	endfunction
	function automatic int subbit(int k);
		return (k < 4) ? k : (k < 8) ? 4 : (k < 24) ? 5 : (k < 27) ? 28 : (k < 30) ? 23 :
			(k < 33) ? 15 : 9;
	endfunction
	function automatic logic [34:0] tosub(word_type p);
		return {1'b0, p[9], 2'b0, p[15], 2'b0, p[23], 2'b0, p[28], 15'h0, p[5], 3'h0, p[4],
			p[3:0]};
	endfunction

	// ****************************************
	// bus and request drivers
	// ****************************************
	task automatic chk(string name, word_type seen, word_type exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(word_type a, word_type dt);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= dt;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdc(string name, word_type a, word_type exp);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask
	task automatic put(word_type p, logic [34:0] sub);
		@(posedge clk);
		src_req <= p;
		{wa, s2, s1, s0, ext} <= sub;
		@(posedge clk);
		src_req <= 32'h0000_0000;
		{wa, s2, s1, s0, ext} <= 35'h0_0000_0000;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// about 3k cycles are expected; 20k cycles means a hang
	initial begin
		#400_000;
		num_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		{rst, wr_s, rd_s} = 3'b100;
		{addr, wdata, src_req} = '0;
		{wa, s2, s1, s0, ext} = 35'h0_0000_0000;
		num_errors = 0;
		checks = 0;
		void'($urandom(32'hfd68_b4af));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdc("src", `IRQ_ADDR_SRC, `IRQ_SRC_RST);
		rdc("mode", `IRQ_ADDR_MODE, `IRQ_MODE_RST);
		rdc("prio", `IRQ_ADDR_PRIO, 32'(`IRQ_PRIO_RST));
		rdc("svc", `IRQ_ADDR_SVC, `IRQ_SVC_RST);
		rdc("index", `IRQ_ADDR_INDEX, 32'(`IRQ_INDEX_RST));
		wr(32'h4A00_0018, 32'h0000_0000);
		rdc("hole", 32'h4A00_0018, 32'h0000_0000);
		rdc("mask", `IRQ_ADDR_MASK, `IRQ_MASK_RST);
		$display("test reset done");
		// every sub-source alone, while all sources are still masked
		for (n = 0; n < 35; n++) begin
			put(32'h0000_0000, 35'h1 << n);
			rdc("map", `IRQ_ADDR_SRC, 32'h1 << subbit(n));
			wr(`IRQ_ADDR_SRC, 32'hFFFF_FFFF);
		end
		put(32'hFFFF_FFFF, 35'h0_0000_0000);
		rdc("direct", `IRQ_ADDR_SRC, 32'hEF7F_7DC0);
		wr(`IRQ_ADDR_SRC, 32'h0F0F_0000);
		rdc("w1c", `IRQ_ADDR_SRC, 32'hE070_7DC0);
		rdc("masked svc", `IRQ_ADDR_SVC, 32'h0000_0000);
		chk("masked irq", 32'(irq), 32'h0000_0000);
		wr(`IRQ_ADDR_SRC, 32'hFFFF_FFFF);
		wr(`IRQ_ADDR_MASK, 32'h0000_0000);
		$display("test mapping done");
		// all 32 sources at priority 0, then random contention under random priority, drained one winner at a time
		for (n = 0; n < 12; n++) begin
			prio_m = (n == 0) ? 21'h00_0000 : 21'($urandom);
			pend = (n == 0) ? 32'hFFFF_FFFF : $urandom;
			wr(`IRQ_ADDR_PRIO, {11'h000, prio_m});
			put(pend, tosub(pend));
			while (pend !== 32'h0000_0000) begin
				w = pick(pend);
				rdc("svc", `IRQ_ADDR_SVC, 32'h1 << w);
				rdc("index", `IRQ_ADDR_INDEX, 32'(w));
				rdc("prio", `IRQ_ADDR_PRIO, {11'h000, prio_m});
				rdc("src", `IRQ_ADDR_SRC, pend);
				chk("irq", 32'(irq), 32'h0000_0001);
				wr(`IRQ_ADDR_SRC, 32'h1 << w);
				wr(`IRQ_ADDR_SVC, 32'h1 << w);
				pend[w] = 1'b0;
			end
			rdc("svc empty", `IRQ_ADDR_SVC, 32'h0000_0000);
			// the line stays up through a whole burst, so one rise per round
			chk("irq taken", 32'(irq_n), 32'(n + 1));
		end
		$display("test arbitration done");
		// a source left pending wins again once its service bit goes
		put(32'h0000_0080, 35'h0_0000_0000);
		wr(`IRQ_ADDR_SVC, 32'h0000_0080);
		rdc("retrigger", `IRQ_ADDR_SVC, 32'h0000_0080);
		wr(`IRQ_ADDR_SRC, 32'h0000_0080);
		wr(`IRQ_ADDR_SVC, 32'h0000_0080);
		rdc("cleared", `IRQ_ADDR_SVC, 32'h0000_0000);
		chk("irq off", 32'(irq), 32'h0000_0000);
		$display("test retrigger done");
		// one fast source beside one normal source in the same cycle
		wr(`IRQ_ADDR_MODE, 32'h0010_0000);
		rdc("mode", `IRQ_ADDR_MODE, 32'h0010_0000);
		put(32'h0010_1000, 35'h0_0000_0000);
		rdc("fast svc", `IRQ_ADDR_SVC, 32'h0000_1000);
		rdc("fast index", `IRQ_ADDR_INDEX, 32'h0000_000C);
		chk("fiq", 32'(fiq), 32'h0000_0001);
		wr(`IRQ_ADDR_SRC, 32'h0010_0000);
		rdc("src left", `IRQ_ADDR_SRC, 32'h0000_1000);
		chk("fiq off", 32'(fiq), 32'h0000_0000);
		chk("fiq taken", 32'(fiq_n), 32'h0000_0001);
		wr(`IRQ_ADDR_SRC, 32'h0000_1000);
		wr(`IRQ_ADDR_SVC, 32'h0000_1000);
		$display("test fast done");
		end_of_test();
	end
endmodule
`default_nettype wire
